// ### hdl/csw_wake_config.sv
// selective-wake configuration registers and their control effects
//
// Operation
// - bit 7 turns oscillator calibration on
// - unlock field 11 unlocks recalibration and wake option writes
// - calibration on and unlocked: trim oscillator against transmit pin
// - unlock code gates wake option writes
// - mask bit 4 gates timeout interrupt
// - selective wake enabled only while valid
// - valid cleared on wake, reset, changes
// - stop mode config write clears valid
// - timeout flag sets only in wake mode, clears in any mode
// - reserved bits always read zero
// - 8-bit quanta per bit, reset A0
// - quantum length follows clock select
// - 6-bit sample fraction, reset 33
// - 29-bit identifier split over four registers
// - standard identifier uses positions 28..18
// - bit 1 selects remote request type
// - bit 0 selects standard or extended
// - mask one compares bit, zero ignores
`timescale 1ns/1ps
module csw_wake_config
   import csw_pkg::*;
(
   // clock and reset
   input  wire logic                       clk,
   input  wire logic                       rst,
   // serial register access
   input  wire logic                       reg_wr,
   input  wire logic                       reg_rd,
   input  wire logic [csw_pkg::ADDR_W-1:0] reg_addr,
   input  wire logic [csw_pkg::DATA_W-1:0] reg_wdata,
   output logic      [csw_pkg::DATA_W-1:0] reg_rdata,
   // chip state and events
   input  wire logic                       stop_mode,
   input  wire logic                       wake_event,
   input  wire logic                       can_cfg_write,
   input  wire logic                       selective_wake_mode,
   input  wire logic                       bus_timeout_event,
   input  wire logic                       bus_timeout_clear,
   input  wire logic [1:0]                 quantum_clock_select,
   input  wire logic                       can_transmit_pin,
   // frame comparison
   input  wire logic                       rx_valid,
   input  wire logic [csw_pkg::IDENT_W-1:0] rx_ident,
   input  wire logic                       rx_rtr,
   input  wire logic                       rx_ext,
   input  wire logic [csw_pkg::IDENT_W-1:0] ident_mask,
   output logic                            ident_match,
   // configuration outputs
   output logic                            calib_mode_on,
   output logic                            recal_unlocked,
   output logic                            alt_receiver_on,
   output logic                            wake_setup_valid,
   output logic                            selective_wake_en,
   output logic [7:0]                      quanta_per_bit,
   output logic [5:0]                      sample_fraction,
   output logic [csw_pkg::IDENT_W-1:0]     wake_ident,
   output logic                            frame_rtr,
   output logic                            frame_ext,
   output logic                            quantum_tick,
   // timeout status and interrupt
   output logic                            bus_timeout_flag,
   output logic                            timeout_irq,
   // trim measurement
   output logic [csw_pkg::TRIM_CNT_W-1:0]  trim_period,
   output logic                            trim_period_valid
);
   import csw_pkg::*;

   logic [7:0] wake_ctrl_q;
   logic [7:0] quanta_q;
   logic [7:0] sample_q;
   logic [7:0] ident3_q;
   logic [7:0] ident2_q;
   logic [7:0] ident1_q;
   logic [7:0] ident0_q;
   logic [7:0] option_q;
   logic       we_ctrl;
   logic       we_quanta;
   logic       we_sample;
   logic       we_id3;
   logic       we_id2;
   logic       we_id1;
   logic       we_id0;
   logic       we_option;
   logic       unlocked;
   logic       cfg_data_write;

   // address decode
   always_comb
   begin
      we_ctrl   = reg_wr && (reg_addr == ADDR_WAKE_CTRL);
      we_quanta = reg_wr && (reg_addr == ADDR_QUANTA);
      we_sample = reg_wr && (reg_addr == ADDR_SAMPLE);
      we_id3    = reg_wr && (reg_addr == ADDR_IDENT3);
      we_id2    = reg_wr && (reg_addr == ADDR_IDENT2);
      we_id1    = reg_wr && (reg_addr == ADDR_IDENT1);
      we_id0    = reg_wr && (reg_addr == ADDR_IDENT0);
      unlocked  = wake_ctrl_q[UNLOCK_HI:UNLOCK_LO] == UNLOCK_CODE;
      we_option = reg_wr && (reg_addr == ADDR_WAKE_OPTION)
                  && unlocked;
      cfg_data_write = we_quanta | we_sample | we_id3 | we_id2
                       | we_id1 | we_id0 | we_option | can_cfg_write;
   end

   // valid bit lives outside the byte cell, so mask it off here
   csw_cfg_byte #(
      .RST_VAL (WAKE_CTRL_RST),
      .WMASK   (WAKE_CTRL_WMASK & ~(8'h01 << SETUP_VALID_BIT))
   ) u_ctrl (
      .clk   (clk),
      .rst   (rst),
      .we    (we_ctrl),
      .wdata (reg_wdata),
      .q     (wake_ctrl_q)
   );

   csw_cfg_byte #(
      .RST_VAL (QUANTA_RST),
      .WMASK   (QUANTA_WMASK)
   ) u_quanta (
      .clk   (clk),
      .rst   (rst),
      .we    (we_quanta),
      .wdata (reg_wdata),
      .q     (quanta_q)
   );

   csw_cfg_byte #(
      .RST_VAL (SAMPLE_RST),
      .WMASK   (SAMPLE_WMASK)
   ) u_sample (
      .clk   (clk),
      .rst   (rst),
      .we    (we_sample),
      .wdata (reg_wdata),
      .q     (sample_q)
   );

   csw_cfg_byte #(
      .RST_VAL (IDENT_RST),
      .WMASK   (IDENT_WMASK)
   ) u_id3 (
      .clk   (clk),
      .rst   (rst),
      .we    (we_id3),
      .wdata (reg_wdata),
      .q     (ident3_q)
   );

   csw_cfg_byte #(
      .RST_VAL (IDENT_RST),
      .WMASK   (IDENT_WMASK)
   ) u_id2 (
      .clk   (clk),
      .rst   (rst),
      .we    (we_id2),
      .wdata (reg_wdata),
      .q     (ident2_q)
   );

   csw_cfg_byte #(
      .RST_VAL (IDENT_RST),
      .WMASK   (IDENT_WMASK)
   ) u_id1 (
      .clk   (clk),
      .rst   (rst),
      .we    (we_id1),
      .wdata (reg_wdata),
      .q     (ident1_q)
   );

   csw_cfg_byte #(
      .RST_VAL (IDENT_RST),
      .WMASK   (IDENT0_WMASK)
   ) u_id0 (
      .clk   (clk),
      .rst   (rst),
      .we    (we_id0),
      .wdata (reg_wdata),
      .q     (ident0_q)
   );

   csw_cfg_byte #(
      .RST_VAL (OPTION_RST),
      .WMASK   (OPTION_WMASK)
   ) u_option (
      .clk   (clk),
      .rst   (rst),
      .we    (we_option),
      .wdata (reg_wdata),
      .q     (option_q)
   );

   // control and status state
   logic                valid_r,    valid_nxt;
   logic                calib_mode_on_r;
   logic                unlocked_r;
   logic                alt_rx_r;
   logic                swk_en_r,   swk_en_nxt;
   logic                to_flag_r,  to_flag_nxt;
   logic                irq_r,      irq_nxt;
   logic [7:0]          rdata_r,    rdata_nxt;
   logic [IDENT_W-1:0]  ident_full;
   logic [IDENT_W-1:0]  ident_r;
   logic                match_r,    match_nxt;
   logic [3:0]          qdiv;
   logic [3:0]          qcnt_r,     qcnt_nxt;
   logic                qtick_r,    qtick_nxt;
   logic                to_event;

   csw_osc_trim #(
      .CNT_W (TRIM_CNT_W)
   ) u_trim (
      .clk              (clk),
      .rst              (rst),
      .trim_enable      (calib_mode_on_r && unlocked_r),
      .can_transmit_pin (can_transmit_pin),
      .period           (trim_period),
      .period_valid     (trim_period_valid)
   );

   always_comb
   begin
      // host set wins over wake clear; stop-mode write forces zero
      valid_nxt = valid_r;
      if (wake_event || cfg_data_write)
      begin
         valid_nxt = 1'b0;
      end
      if (we_ctrl)
      begin
         valid_nxt = reg_wdata[SETUP_VALID_BIT];
      end
      if (stop_mode && (we_ctrl || cfg_data_write))
      begin
         valid_nxt = 1'b0;
      end
      swk_en_nxt = valid_nxt;

      // flag only sets while selective wake mode is set; clear works in any mode
      to_event    = bus_timeout_event && selective_wake_mode;
      to_flag_nxt = to_flag_r;
      if (bus_timeout_clear)
      begin
         to_flag_nxt = 1'b0;
      end
      if (to_event)
      begin
         to_flag_nxt = 1'b1;
      end
      irq_nxt = to_event && wake_ctrl_q[IRQ_ALLOW_BIT];

      // identifier assembly and masked compare
      ident_full = {ident3_q, ident2_q, ident1_q,
                    ident0_q[ID_LOW_HI:ID_LOW_LO]};
      match_nxt = 1'b0;
      if (rx_valid)
      begin
         // standard frames compare only positions 28..18
         if (!ident0_q[EXT_BIT])
         begin
            match_nxt = ((((rx_ident ^ ident_full) & ident_mask)
                         >> STD_LSB) == '0);
         end
         else
         begin
            match_nxt = (((rx_ident ^ ident_full) & ident_mask)
                        == '0);
         end
         match_nxt = match_nxt && (rx_ext == ident0_q[EXT_BIT])
                     && (rx_rtr == ident0_q[RTR_BIT]);
      end

      // quantum length from oscillator clock selection
      unique case (quantum_clock_select)
         2'h0: qdiv = QDIV_SEL0;
         2'h1: qdiv = QDIV_SEL1;
         2'h2: qdiv = QDIV_SEL2;
         2'h3: qdiv = QDIV_SEL3;
      endcase
      qtick_nxt = 1'b0;
      qcnt_nxt  = qcnt_r + 4'h1;
      if (qcnt_nxt >= qdiv)
      begin
         qcnt_nxt  = 4'h0;
         qtick_nxt = 1'b1;
      end

      // readback, reserved bits come back zero
      rdata_nxt = rdata_r;
      if (reg_rd)
      begin
         unique case (reg_addr)
            ADDR_WAKE_CTRL:   rdata_nxt = {wake_ctrl_q[7:1], valid_r};
            ADDR_QUANTA:      rdata_nxt = quanta_q;
            ADDR_SAMPLE:      rdata_nxt = sample_q;
            ADDR_IDENT3:      rdata_nxt = ident3_q;
            ADDR_IDENT2:      rdata_nxt = ident2_q;
            ADDR_IDENT1:      rdata_nxt = ident1_q;
            ADDR_IDENT0:      rdata_nxt = ident0_q;
            ADDR_WAKE_OPTION: rdata_nxt = option_q;
            default:          rdata_nxt = READ_UNMAPPED;
         endcase
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         valid_r         <= 1'b0;
         calib_mode_on_r <= 1'b0;
         unlocked_r      <= 1'b0;
         alt_rx_r        <= 1'b0;
         swk_en_r        <= 1'b0;
         to_flag_r       <= 1'b0;
         irq_r           <= 1'b0;
         rdata_r         <= 8'h00;
         ident_r         <= '0;
         match_r         <= 1'b0;
         qcnt_r          <= 4'h0;
         qtick_r         <= 1'b0;
      end
      else
      begin
         valid_r         <= valid_nxt;
         calib_mode_on_r <= wake_ctrl_q[CALIB_BIT];
         unlocked_r      <= unlocked;
         alt_rx_r        <= option_q[0];
         swk_en_r        <= swk_en_nxt;
         to_flag_r       <= to_flag_nxt;
         irq_r           <= irq_nxt;
         rdata_r         <= rdata_nxt;
         ident_r         <= ident_full;
         match_r         <= match_nxt;
         qcnt_r          <= qcnt_nxt;
         qtick_r         <= qtick_nxt;
      end
   end

   // outputs straight from flops
   assign reg_rdata         = rdata_r;
   assign calib_mode_on     = calib_mode_on_r;
   assign recal_unlocked    = unlocked_r;
   assign alt_receiver_on   = alt_rx_r;
   assign wake_setup_valid  = valid_r;
   assign selective_wake_en = swk_en_r;
   assign quanta_per_bit    = quanta_q;
   assign sample_fraction   = sample_q[5:0];
   assign wake_ident        = ident_r;
   assign frame_rtr         = ident0_q[RTR_BIT];
   assign frame_ext         = ident0_q[EXT_BIT];
   assign quantum_tick      = qtick_r;
   assign bus_timeout_flag  = to_flag_r;
   assign timeout_irq       = irq_r;
   assign ident_match       = match_r;
endmodule : csw_wake_config

// ### hdl/csw_pkg.sv
// constants for the selective-wake configuration block
package csw_pkg;
   localparam int   ADDR_W            = 7;
   localparam int   DATA_W            = 8;
   localparam int   IDENT_W           = 29;

   // register addresses
   localparam logic [6:0] ADDR_WAKE_CTRL   = 7'h20;
   localparam logic [6:0] ADDR_QUANTA      = 7'h21;
   localparam logic [6:0] ADDR_SAMPLE      = 7'h22;
   localparam logic [6:0] ADDR_IDENT3      = 7'h23;
   localparam logic [6:0] ADDR_IDENT2      = 7'h24;
   localparam logic [6:0] ADDR_IDENT1      = 7'h25;
   localparam logic [6:0] ADDR_IDENT0      = 7'h26;
   localparam logic [6:0] ADDR_WAKE_OPTION = 7'h3C;

   // wake control field positions
   localparam int   CALIB_BIT         = 7;
   localparam int   UNLOCK_HI         = 6;
   localparam int   UNLOCK_LO         = 5;
   localparam int   IRQ_ALLOW_BIT     = 4;
   localparam int   SETUP_VALID_BIT   = 0;
   localparam logic [1:0] UNLOCK_CODE = 2'h3;

   // lowest identifier register field positions
   localparam int   ID_LOW_HI         = 6;
   localparam int   ID_LOW_LO         = 2;
   localparam int   RTR_BIT           = 1;
   localparam int   EXT_BIT           = 0;
   localparam int   STD_LSB           = 18;

   // reset values and writable masks
   localparam logic [7:0] WAKE_CTRL_RST   = 8'h00;
   localparam logic [7:0] WAKE_CTRL_WMASK = 8'hF1;
   localparam logic [7:0] QUANTA_RST      = 8'hA0;
   localparam logic [7:0] QUANTA_WMASK    = 8'hFF;
   localparam logic [7:0] SAMPLE_RST      = 8'h33;
   localparam logic [7:0] SAMPLE_WMASK    = 8'h3F;
   localparam logic [7:0] IDENT_RST       = 8'h00;
   localparam logic [7:0] IDENT_WMASK     = 8'hFF;
   localparam logic [7:0] IDENT0_WMASK    = 8'h7F;
   localparam logic [7:0] OPTION_RST      = 8'h00;
   localparam logic [7:0] OPTION_WMASK    = 8'h01;
   localparam logic [7:0] READ_UNMAPPED   = 8'h00;

   // quantum divider: cycles per quantum for each clock selection
   localparam logic [3:0] QDIV_SEL0 = 4'h1;
   localparam logic [3:0] QDIV_SEL1 = 4'h2;
   localparam logic [3:0] QDIV_SEL2 = 4'h4;
   localparam logic [3:0] QDIV_SEL3 = 4'h8;

   localparam int   TRIM_CNT_W        = 16;
endpackage : csw_pkg

// ### hdl/csw_cfg_byte.sv
// one configuration byte with reset value and writable bit mask
`timescale 1ns/1ps
module csw_cfg_byte #(
   parameter logic [7:0] RST_VAL = 8'h00,
   parameter logic [7:0] WMASK   = 8'hFF
) (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   // write side
   input  wire logic       we,
   input  wire logic [7:0] wdata,
   // stored value
   output logic      [7:0] q
);
   logic [7:0] q_r;
   logic [7:0] q_nxt;

   // masked bits keep their reset value, reserved ones stay zero
   always_comb
   begin
      q_nxt = q_r;
      if (we)
      begin
         q_nxt = (q_r & ~WMASK) | (wdata & WMASK);
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         q_r <= RST_VAL;
      end
      else
      begin
         q_r <= q_nxt;
      end
   end

   assign q = q_r;
endmodule : csw_cfg_byte

// ### hdl/csw_osc_trim.sv
// measures the transmit-pin reference period for oscillator trimming
`timescale 1ns/1ps
module csw_osc_trim #(
   parameter int CNT_W = 16
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             rst,
   // control and reference
   input  wire logic             trim_enable,
   input  wire logic             can_transmit_pin,
   // measurement
   output logic      [CNT_W-1:0] period,
   output logic                  period_valid
);
   logic             pin_prev_r;
   logic             armed_r;
   logic [CNT_W-1:0] count_r;
   logic [CNT_W-1:0] period_r;
   logic             valid_r;
   logic             armed_nxt;
   logic [CNT_W-1:0] count_nxt;
   logic [CNT_W-1:0] period_nxt;
   logic             valid_nxt;
   logic             fall;

   // count clock cycles between falling edges of the reference
   always_comb
   begin
      fall       = pin_prev_r & ~can_transmit_pin;
      armed_nxt  = armed_r;
      count_nxt  = count_r;
      period_nxt = period_r;
      valid_nxt  = 1'b0;
      if (!trim_enable)
      begin
         armed_nxt = 1'b0;
         count_nxt = '0;
      end
      else if (fall)
      begin
         armed_nxt = 1'b1;
         count_nxt = '0;
         if (armed_r)
         begin
            period_nxt = count_r + CNT_W'(1);
            valid_nxt  = 1'b1;
         end
      end
      else if (count_r != '1)
      begin
         // saturate rather than wrap on a stuck reference
         count_nxt = count_r + CNT_W'(1);
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         pin_prev_r <= 1'b1;
         armed_r    <= 1'b0;
         count_r    <= '0;
         period_r   <= '0;
         valid_r    <= 1'b0;
      end
      else
      begin
         pin_prev_r <= can_transmit_pin;
         armed_r    <= armed_nxt;
         count_r    <= count_nxt;
         period_r   <= period_nxt;
         valid_r    <= valid_nxt;
      end
   end

   assign period       = period_r;
   assign period_valid = valid_r;
endmodule : csw_osc_trim

// ### sim/csw_wake_config_assertions.sv
// concurrent checks on the selective-wake configuration ports
`timescale 1ns/1ps
module csw_wake_config_chk
   import csw_pkg::*;
(
   // clock and reset
   input wire logic        clk,
   input wire logic        rst,
   // register access and events
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [6:0]  reg_addr,
   input wire logic [7:0]  reg_wdata,
   input wire logic        stop_mode,
   input wire logic        wake_event,
   input wire logic        can_cfg_write,
   input wire logic        selective_wake_mode,
   input wire logic        bus_timeout_event,
   input wire logic        rx_valid,
   // observed outputs
   input wire logic [7:0]  reg_rdata,
   input wire logic        wake_setup_valid,
   input wire logic        selective_wake_en,
   input wire logic [7:0]  quanta_per_bit,
   input wire logic        bus_timeout_flag,
   input wire logic        timeout_irq,
   input wire logic        ident_match
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   valid_load_a: assert property (reg_wr && !stop_mode &&
      reg_addr == ADDR_WAKE_CTRL |=> wake_setup_valid == $past(reg_wdata[0]))
      else $error("valid bit not loaded from write");
   wake_gate_a: assert property (
      selective_wake_en == wake_setup_valid)
      else $error("wake enable differs from valid bit");
   wake_clear_a: assert property (wake_event && !reg_wr
      |=> !wake_setup_valid) else $error("valid kept after wake");
   cfg_clear_a: assert property (reg_wr &&
      reg_addr inside {[ADDR_QUANTA:ADDR_IDENT0]} |=> !wake_setup_valid)
      else $error("valid kept after config change");
   stop_clear_a: assert property (stop_mode && (can_cfg_write ||
      reg_wr && reg_addr == ADDR_WAKE_CTRL) |=> !wake_setup_valid)
      else $error("valid kept after stop mode write");
   flag_set_a: assert property (bus_timeout_event &&
      selective_wake_mode |=> bus_timeout_flag) else $error("flag not set");
   flag_cause_a: assert property ($rose(bus_timeout_flag) |->
      $past(bus_timeout_event && selective_wake_mode))
      else $error("flag rose without timeout in wake mode");
   irq_cause_a: assert property (timeout_irq |->
      bus_timeout_flag && $past(bus_timeout_event && selective_wake_mode))
      else $error("interrupt without a taken timeout");
   quanta_read_a: assert property (reg_rd && !reg_wr &&
      reg_addr == ADDR_QUANTA |=> reg_rdata == quanta_per_bit)
      else $error("quanta read differs from output");
   match_cause_a: assert property (
      ident_match |-> $past(rx_valid))
      else $error("match without received frame");
endmodule : csw_wake_config_chk

bind csw_wake_config csw_wake_config_chk u_chk (.clk, .rst, .reg_wr,
   .reg_rd, .reg_addr, .reg_wdata, .stop_mode, .wake_event, .can_cfg_write,
   .selective_wake_mode, .bus_timeout_event, .rx_valid, .reg_rdata,
   .wake_setup_valid, .selective_wake_en, .quanta_per_bit,
   .bus_timeout_flag, .timeout_irq, .ident_match);

// ### sim/csw_tx_ref.sv
// host side reference square wave on the transmit pin for trimming
`timescale 1ns/1ps
module csw_tx_ref (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   // control
   input  wire logic       run,
   input  wire logic [3:0] half,
   // reference pin
   output logic            can_transmit_pin
);
   logic [3:0] cnt_r, cnt_nxt;
   logic       pin_r, pin_nxt;

   always_comb
   begin
      cnt_nxt = cnt_r + 4'h1;
      pin_nxt = pin_r;
      if (!run)
      begin
         cnt_nxt = 4'h0;
         pin_nxt = 1'b1; // recessive level while idle
      end
      else if (cnt_r == half - 4'h1)
      begin
         cnt_nxt = 4'h0;
         pin_nxt = !pin_r;
      end
   end

   always_ff @(posedge clk)
   begin
      cnt_r <= rst ? 4'h0 : cnt_nxt;
      pin_r <= rst ? 1'b1 : pin_nxt;
   end
   assign can_transmit_pin = pin_r;
endmodule : csw_tx_ref

// ### sim/csw_wake_config_tb.sv
// self-checking bench for the selective-wake configuration block
`timescale 1ns/1ps
module csw_wake_config_tb;
   import csw_pkg::*;
   logic        clk, rst, reg_wr, reg_rd, stop_mode, selective_wake_mode;
   logic        can_transmit_pin, ident_match, calib_mode_on, recal_unlocked;
   logic        alt_receiver_on, wake_setup_valid, selective_wake_en;
   logic        frame_rtr, frame_ext, quantum_tick, bus_timeout_flag;
   logic        timeout_irq, trim_period_valid, rx_rtr, rx_ext, tx_run, rd_d;
   logic [4:0]  pv;
   logic [6:0]  reg_addr;
   logic [7:0]  reg_wdata, reg_rdata, quanta_per_bit;
   logic [5:0]  sample_fraction;
   logic [1:0]  quantum_clock_select;
   logic [28:0] rx_ident, ident_mask, wake_ident, v;
   logic [15:0] trim_period;
   logic [7:0]  exp_q[$];
   int          n_mismatch, checks_done, irq_cnt, tick_cnt, i;

   csw_wake_config uut (.clk, .rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
      .reg_rdata, .stop_mode, .wake_event(pv[0]), .can_cfg_write(pv[1]),
      .selective_wake_mode, .bus_timeout_event(pv[2]),
      .bus_timeout_clear(pv[3]), .quantum_clock_select, .can_transmit_pin,
      .rx_valid(pv[4]), .rx_ident, .rx_rtr, .rx_ext, .ident_mask,
      .ident_match, .calib_mode_on, .recal_unlocked, .alt_receiver_on,
      .wake_setup_valid, .selective_wake_en, .quanta_per_bit,
      .sample_fraction, .wake_ident, .frame_rtr, .frame_ext, .quantum_tick,
      .bus_timeout_flag, .timeout_irq, .trim_period, .trim_period_valid);

   csw_tx_ref host (.clk, .rst, .run(tx_run), .half(4'h5), .can_transmit_pin);

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [6:0] a, input logic [7:0] e);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      exp_q.push_back(e);
      @(posedge clk);
      reg_rd <= 1'b0;
   endtask : rd

   task automatic pulse(input int k);
      @(posedge clk);
      pv[k] <= 1'b1;
      @(posedge clk);
      pv <= '0;
   endtask : pulse

   task automatic st;
      repeat (2) @(posedge clk);
      @(negedge clk);
   endtask : st

   // identifier bytes; reserved top bit always written as one
   task automatic wid(input logic [28:0] x, input logic [1:0] f);
      wr(ADDR_IDENT3, x[28:21]);
      wr(ADDR_IDENT2, x[20:13]);
      wr(ADDR_IDENT1, x[12:5]);
      wr(ADDR_IDENT0, {1'b1, x[4:0], f});
      st;
   endtask : wid

   task automatic rx(input logic [28:0] id, input logic [1:0] f,
                     input logic e);
      @(posedge clk);
      rx_ident <= id;
      {rx_rtr, rx_ext} <= f;
      pv[4] <= 1'b1;
      @(posedge clk);
      pv <= '0;
      @(negedge clk);
      chk(ident_match, e);
   endtask : rx

   task automatic conclude;
      $display("checks=%0d mismatches=%0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : conclude

   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   always @(posedge clk)
   begin
      rd_d <= reg_rd;
      if (timeout_irq === 1'b1) irq_cnt <= irq_cnt + 1;
      if (quantum_tick === 1'b1) tick_cnt <= tick_cnt + 1;
   end

   // read data shows one cycle after the strobe
   always @(negedge clk)
      if (rd_d === 1'b1 && exp_q.size() > 0)
         chk(reg_rdata, exp_q.pop_front());

   initial
   begin
      #100000;
      n_mismatch++;
      conclude;
   end

   initial
   begin
      rst = 1'b1;
      {pv, reg_wr, reg_rd, stop_mode, selective_wake_mode, rx_rtr} = '0;
      {rx_ext, tx_run, reg_addr, reg_wdata, quantum_clock_select} = '0;
      rx_ident = '0;
      ident_mask = '1;
      void'($urandom(32'h5C9F47BC));
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      for (i = 0; i < 7; i++)
         rd(7'h20 + i[6:0],
            i == 1 ? 8'hA0 : i == 2 ? 8'h33 : 8'h00);
      wr(7'h7F, 8'hFF);
      rd(7'h7F, 8'h00);
      $display("test reset_values done");
      // remote-request bit kept clear in every write
      for (i = 6; i >= 0; i--)
         wr(7'h20 + i[6:0], 8'hFD);
      st;
      for (i = 0; i < 7; i++)
         rd(7'h20 + i[6:0],
            i == 0 ? 8'hF1 : i == 2 ? 8'h3D : i == 6 ? 8'h7D : 8'hFD);
      chk(wake_ident, 29'h1FBFBFBF);
      chk({frame_rtr, frame_ext}, 2'b01);
      chk(sample_fraction, 6'h3D);
      chk(quanta_per_bit, 8'hFD);
      v = 29'($urandom());
      wid(v, 2'b00);
      chk(wake_ident, v);
      chk(wake_setup_valid, 1'b0);
      rd(ADDR_IDENT0, {1'b0, v[4:0], 2'b00});
      $display("test register_map done");
      for (i = 0; i < 3; i++)
      begin
         wr(ADDR_WAKE_CTRL, 8'h01);
         st;
         chk({wake_setup_valid, selective_wake_en}, 2'b11);
         @(posedge clk);
         stop_mode <= i == 2;
         if (i < 2) pulse(i);
         else wr(ADDR_WAKE_CTRL, 8'h01);
         st;
         chk(wake_setup_valid, 1'b0);
      end
      @(posedge clk);
      stop_mode <= 1'b0;
      $display("test valid_clear done");
      for (i = 0; i < 4; i++)
      begin
         wr(ADDR_WAKE_CTRL, {i[0], i[1:0], 5'h00});
         wr(ADDR_WAKE_OPTION, 8'h01);
         st;
         chk(recal_unlocked, i == 3);
         chk(calib_mode_on, i[0]);
         chk(alt_receiver_on, i == 3);
      end
      rd(ADDR_WAKE_OPTION, 8'h01);
      $display("test unlock done");
      for (i = 0; i < 3; i++)
      begin
         @(posedge clk);
         selective_wake_mode <= i > 0;
         wr(ADDR_WAKE_CTRL, i == 2 ? 8'h10 : 8'h00);
         st;
         irq_cnt = 0;
         pulse(2);
         st;
         chk(bus_timeout_flag, i > 0);
         chk(irq_cnt, i == 2);
         pulse(3);
         st;
         chk(bus_timeout_flag, 1'b0);
      end
      $display("test timeout done");
      v = 29'($urandom());
      wid(v, 2'b00);
      rx(v ^ 29'h1, 2'b00, 1'b1);
      rx(v ^ 29'h100000, 2'b00, 1'b0);
      @(posedge clk);
      ident_mask <= ~29'h100000;
      rx(v ^ 29'h100000, 2'b00, 1'b1);
      rx(v, 2'b10, 1'b0);
      rx(v, 2'b01, 1'b0);
      wid(v, 2'b01);
      rx(v ^ 29'h1, 2'b01, 1'b0);
      rx(v, 2'b01, 1'b1);
      $display("test match done");
      wr(ADDR_WAKE_CTRL, 8'hE0);
      @(posedge clk);
      tx_run <= 1'b1;
      for (i = 0; i < 60 && trim_period_valid !== 1'b1; i++)
         @(negedge clk);
      chk({trim_period_valid, trim_period}, 17'h1000A);
      @(posedge clk);
      tx_run <= 1'b0;
      for (i = 0; i < 4; i++)
      begin
         @(posedge clk);
         quantum_clock_select <= i[1:0];
         repeat (8) @(negedge clk);
         tick_cnt = 0;
         repeat (16) @(negedge clk);
         chk(tick_cnt, 16 >> i);
      end
      $display("test trim_and_quantum done");
      conclude;
   end
endmodule : csw_wake_config_tb
